//--- floppy_io_cfg.svh
`ifndef FLOPPY_IO_CFG_SVH
`define FLOPPY_IO_CFG_SVH

// Clock period
`define CLK_PERIOD_NS 25

// Device field: high digit fixed at 7, low digit from switches
`define DEV_HIGH_DIGIT 3'h7

// Command word fields (bit 0 here is the lsb, host bit 11)
`define CMD_FUNC_HI 3
`define CMD_FUNC_LO 1
`define CMD_DRIVE_BIT 4
`define CMD_MODE_BIT 6
`define CMD_MAINT_BIT 7
`define AC_IE_BIT 0

// Host word layout for 8-bit transfers
`define AC_BYTE_HI 7
`define AC_HIGH_HI 11
`define AC_HIGH_LO 8

// Words per sector
`define SECTOR_WORDS_12 8'h40
`define SECTOR_WORDS_8 8'h80

// Request pacing after service
`define PACE_12_US 23
`define PACE_8_US 18

// Longest initialize
`define INIT_MAX_MS 1800

// Reset values
`define WORD_ZERO 12'h000
`define COUNT_ZERO 8'h00

`endif

//--- floppy_io_pkg.sv
package floppy_io_pkg;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_LOAD_COMMAND = 3'h1,
        OP_TRANSFER_DATA = 3'h2,
        OP_SKIP_TRANSFER_REQUEST = 3'h3,
        OP_SKIP_ERROR = 3'h4,
        OP_SKIP_DONE = 3'h5,
        OP_INTERRUPT_CONTROL = 3'h6,
        OP_INITIALIZE = 3'h7
    } io_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_BUSY = 2'h1,
        ST_INIT = 2'h2
    } ctl_state_t;

endpackage

//--- transfer_pace_timer.sv
`timescale 1ns/1ps
`include "floppy_io_cfg.svh"

module transfer_pace_timer #(
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic eight_bit,
    output logic ready
);
    localparam int PACE12_CYC = (`PACE_12_US * 1000) / `CLK_PERIOD_NS;
    localparam int PACE8_CYC = (`PACE_8_US * 1000) / `CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] LOAD12 = CNT_W'(PACE12_CYC - 1);
    localparam logic [CNT_W-1:0] LOAD8 = CNT_W'(PACE8_CYC - 1);

    logic [CNT_W-1:0] cnt_q;

    // Counts down the gap after each serviced request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= eight_bit ? LOAD8 : LOAD12;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    // Ready once the gap has fully run
    assign ready = (cnt_q == '0) && !start;
endmodule

//--- floppy_host_io_interface.sv
`timescale 1ns/1ps
`include "floppy_io_cfg.svh"
// Notes on behaviour
// - Sector holds 64 or 128 words
// - 12-bit sectors padded with zeros
// - Request raised 23 or 18 us after service
// - Pending request held until host services it
// - Device code 70-77 from three switches
// - Load command copies accumulator, clears it
// - No new function before previous completes
// - Transfer data moves word, tells controller proceed
// - Write leaves accumulator unchanged, loads all bits
// - 12-bit read jams, 8-bit read ORs byte
// - After done, transfer returns status word
// - Skip on transfer request, clear it
// - Skip on error, clear; error sets done
// - Skip on done, clear done flag
// - Accumulator bit 11 enables done interrupt
// - Initialize clears status, sets done, 1.8 s max
// - Initialize by instruction or bus reset
// - One register serves all six roles
// - Command bits 8-10 give function code
// - Command bit 7 selects drive
// - Command bit 5 selects mode; init 12-bit
// - Command bit 4 enters maintenance mode
// - Programmed initialize clears flags and enable

module floppy_host_io_interface #(
    parameter int INIT_MAX_CYCLES = (`INIT_MAX_MS * 1000) / `CLK_PERIOD_NS * 1000,
    parameter int INIT_W = 27
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic io_strobe,
    input wire logic [5:0] io_device,
    input wire floppy_io_pkg::io_op_t io_op,
    input wire logic [11:0] ac_in,
    input wire logic [2:0] dev_switch,
    input wire logic bus_init,
    output logic [11:0] ac_out,
    output logic ac_load,
    output logic skip,
    output logic irq,
    output logic [11:0] ctl_data_out,
    input wire logic [11:0] ctl_data_in,
    input wire logic ctl_load,
    input wire logic ctl_to_host,
    input wire logic ctl_tr_req,
    input wire logic ctl_done,
    input wire logic ctl_error,
    output logic ctl_run,
    output logic ctl_init,
    output logic [2:0] ctl_function,
    output logic ctl_drive,
    output logic ctl_eight_bit,
    output logic maint_mode,
    output logic sector_full
);
    import floppy_io_pkg::*;

    ctl_state_t state_q;
    logic [11:0] iface_q;
    logic [11:0] ac_out_q;
    logic ac_load_q, skip_q, run_q, init_q;
    logic tr_q, err_q, done_q, ie_q, maint_q, eight_q, pend_q;
    logic [2:0] func_q;
    logic drive_q;
    logic [7:0] word_cnt_q;
    logic [INIT_W-1:0] init_cnt_q;
    logic hit, lcd_hit, lcd_ok, xdr_hit, xdr_read, xdr_write, xdr_proceed;
    logic str_hit, ser_hit, sdn_hit, interrupt_control_instr_hit, init_go, pace_ready, pad_active;
    logic tr_set, init_timeout;
    logic [7:0] sector_limit;
    logic [11:0] read_word;

    // Instruction decode against the switch code
    assign hit = io_strobe && (io_device == {`DEV_HIGH_DIGIT, dev_switch});
    assign lcd_hit = hit && (io_op == OP_LOAD_COMMAND);
    assign lcd_ok = lcd_hit && (state_q == ST_IDLE);
    assign xdr_hit = hit && (io_op == OP_TRANSFER_DATA);
    assign xdr_read = xdr_hit && (maint_q || state_q != ST_BUSY || ctl_to_host);
    assign xdr_write = xdr_hit && !xdr_read;
    assign xdr_proceed = xdr_hit && !maint_q && (state_q == ST_BUSY);
    assign str_hit = hit && (io_op == OP_SKIP_TRANSFER_REQUEST);
    assign ser_hit = hit && (io_op == OP_SKIP_ERROR);
    assign sdn_hit = hit && (io_op == OP_SKIP_DONE);
    assign interrupt_control_instr_hit = hit && (io_op == OP_INTERRUPT_CONTROL);
    assign init_go = (hit && (io_op == OP_INITIALIZE)) || bus_init;

    // Sector length and zero padding
    assign sector_limit = eight_q ? `SECTOR_WORDS_8 : `SECTOR_WORDS_12;
    assign sector_full = (word_cnt_q >= sector_limit);
    assign pad_active = (state_q == ST_BUSY) && !eight_q && sector_full;
    assign ctl_data_out = pad_active ? `WORD_ZERO : iface_q;

    // Read merge: jam in 12-bit, OR the byte in 8-bit
    assign read_word = eight_q ?
        {ac_in[`AC_HIGH_HI:`AC_HIGH_LO], ac_in[`AC_BYTE_HI:0] | iface_q[`AC_BYTE_HI:0]} :
        iface_q;

    // Request reaches the host only after the pacing gap
    assign tr_set = pend_q && pace_ready && !pad_active;
    assign init_timeout = (state_q == ST_INIT) &&
        (init_cnt_q == INIT_W'(INIT_MAX_CYCLES - 1));

    transfer_pace_timer #(
        .CNT_W(10)
    ) u_pace (
        .clk(clk),
        .rst_n(rst_n),
        .start(xdr_proceed),
        .eight_bit(eight_q),
        .ready(pace_ready)
    );

    // Controller sequencing state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else if (init_go) begin
            state_q <= ST_INIT;
        end else if (ctl_done || ctl_error || init_timeout) begin
            state_q <= ST_IDLE;
        end else if (lcd_ok && !maint_q) begin
            state_q <= ST_BUSY;
        end
    end

    // Initialize watchdog
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt_q <= '0;
        end else if (init_go || state_q != ST_INIT) begin
            init_cnt_q <= '0;
        end else begin
            init_cnt_q <= init_cnt_q + INIT_W'(1);
        end
    end

    // The single interface register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            iface_q <= `WORD_ZERO;
        end else if (init_go) begin
            iface_q <= `WORD_ZERO;
        end else if (lcd_ok || xdr_write) begin
            iface_q <= ac_in;
        end else if (ctl_load && !maint_q) begin
            iface_q <= ctl_data_in;
        end
    end

    // Command fields, mode and maintenance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            func_q <= 3'h0;
            drive_q <= 1'b0;
            eight_q <= 1'b0;
            maint_q <= 1'b0;
        end else if (init_go) begin
            eight_q <= 1'b0;
            maint_q <= 1'b0;
        end else if (lcd_ok) begin
            func_q <= ac_in[`CMD_FUNC_HI:`CMD_FUNC_LO];
            drive_q <= ac_in[`CMD_DRIVE_BIT];
            eight_q <= ac_in[`CMD_MODE_BIT];
            maint_q <= ac_in[`CMD_MAINT_BIT];
        end
    end

    // Host accumulator answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ac_out_q <= `WORD_ZERO;
            ac_load_q <= 1'b0;
        end else begin
            ac_load_q <= lcd_hit || xdr_read;
            if (lcd_hit) begin
                ac_out_q <= `WORD_ZERO;
            end else if (xdr_read) begin
                ac_out_q <= read_word;
            end
        end
    end

    // Skip answer for the three test instructions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= (str_hit && tr_q) || (ser_hit && err_q) || (sdn_hit && done_q);
        end
    end

    // Controller strobes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            init_q <= 1'b0;
        end else begin
            run_q <= (lcd_ok && !maint_q) || xdr_proceed ||
                (ctl_tr_req && pad_active);
            init_q <= init_go;
        end
    end

    // Pending request from the controller
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (init_go) begin
            pend_q <= 1'b0;
        end else if (ctl_tr_req && !pad_active) begin
            pend_q <= 1'b1;
        end else if (tr_set) begin
            pend_q <= 1'b0;
        end
    end

    // Words moved in the current sector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_cnt_q <= `COUNT_ZERO;
        end else if (init_go || lcd_ok) begin
            word_cnt_q <= `COUNT_ZERO;
        end else if ((xdr_proceed || (ctl_tr_req && pad_active)) && word_cnt_q != 8'hff) begin
            word_cnt_q <= word_cnt_q + 8'h01;
        end
    end

    // Flags: initialize clears all; otherwise a set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tr_q <= 1'b0;
            err_q <= 1'b0;
            done_q <= 1'b0;
        end else if (init_go) begin
            tr_q <= 1'b0;
            err_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (tr_set || maint_q) begin
                tr_q <= 1'b1;
            end else if (str_hit) begin
                tr_q <= 1'b0;
            end
            if (ctl_error || init_timeout || maint_q) begin
                err_q <= 1'b1;
            end else if (ser_hit) begin
                err_q <= 1'b0;
            end
            if (ctl_done || ctl_error || init_timeout || maint_q) begin
                done_q <= 1'b1;
            end else if (sdn_hit || lcd_ok) begin
                done_q <= 1'b0;
            end
        end
    end

    // Interrupt enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_q <= 1'b0;
        end else if (init_go) begin
            ie_q <= 1'b0;
        end else if (interrupt_control_instr_hit) begin
            ie_q <= ac_in[`AC_IE_BIT];
        end
    end

    // Outputs
    assign ac_out = ac_out_q;
    assign ac_load = ac_load_q;
    assign skip = skip_q;
    assign irq = done_q && ie_q;
    assign ctl_run = run_q;
    assign ctl_init = init_q;
    assign ctl_function = func_q;
    assign ctl_drive = drive_q;
    assign ctl_eight_bit = eight_q;
    assign maint_mode = maint_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_lcd_clears_ac: assert property (lcd_hit |=> ac_load && ac_out == `WORD_ZERO)
        else $error("load command did not clear accumulator");
    a_lcd_busy_held: assert property (lcd_hit && state_q != ST_IDLE && !init_go
        |=> $stable(func_q))
        else $error("function changed while busy");
    a_xdr_write_keep: assert property (xdr_write |=> !ac_load)
        else $error("write transfer changed accumulator");
    a_xdr_byte_merge: assert property (xdr_read && eight_q && !lcd_hit
        |=> ac_out[11:8] == $past(ac_in[11:8]))
        else $error("8-bit read touched high bits");
    a_str_skip_clear: assert property (str_hit && tr_q && !tr_set && !maint_q && !init_go
        |=> skip && !tr_q)
        else $error("transfer request skip wrong");
    a_error_sets_done: assert property (ctl_error && !init_go |=> done_q && err_q)
        else $error("error did not set done");
    a_sdn_skip_clear: assert property (sdn_hit && done_q && !ctl_done && !ctl_error
        && !maint_q && !init_go && !init_timeout |=> skip && !done_q)
        else $error("done skip wrong");
    a_interrupt_control_instr_enable: assert property (interrupt_control_instr_hit && !init_go |=> ie_q == $past(ac_in[`AC_IE_BIT]))
        else $error("interrupt enable not loaded");
    a_init_clears: assert property (init_go |=> !tr_q && !done_q && !ie_q && !eight_q
        && iface_q == `WORD_ZERO ##0 ctl_init)
        else $error("initialize did not clear state");
    a_tr_paced: assert property ($rose(tr_q) && !$past(maint_q) |-> $past(pace_ready))
        else $error("request raised inside pacing gap");
    a_foreign_code: assert property (io_strobe && !hit && !bus_init
        |=> !ac_load && !skip && !ctl_run)
        else $error("foreign device code acted");
    a_nop_quiet: assert property (hit && io_op == OP_NOP && !ctl_tr_req
        |=> !ac_load && !skip && !ctl_run && $stable(iface_q))
        else $error("no-op changed state");
endmodule

//--- controller_model.sv
`timescale 1ns/1ps

module controller_model #(
    parameter int DLY = 6,
    parameter int WORDS = 3,
    parameter logic [11:0] STATUS = 12'h2c5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_run,
    input wire logic ctl_init,
    input wire logic [2:0] ctl_function,
    input wire logic fail,
    output logic [11:0] ctl_data_in,
    output logic ctl_load,
    output logic ctl_to_host,
    output logic ctl_tr_req,
    output logic ctl_done,
    output logic ctl_error
);
    logic busy_q;
    logic words_q;
    logic init_q;
    int wait_q;
    int cnt_q;

    // Microprogram stand-in; data bus toggles whenever no word is offered
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {busy_q, words_q, init_q, ctl_load, ctl_to_host} <= '0;
            {ctl_tr_req, ctl_done, ctl_error} <= '0;
            ctl_data_in <= 12'h000;
            wait_q <= 0;
            cnt_q <= 0;
        end else begin
            {ctl_load, ctl_tr_req, ctl_done, ctl_error} <= '0;
            ctl_data_in <= ~ctl_data_in;
            if (ctl_init || (ctl_run && !busy_q)) begin
                busy_q <= 1'b1;
                init_q <= ctl_init;
                words_q <= !ctl_init && ctl_function[2:1] == 2'h0;
                ctl_to_host <= !ctl_init && ctl_function == 3'h1;
                cnt_q <= WORDS;
                wait_q <= DLY;
            end else if (ctl_run) begin
                wait_q <= DLY;
            end else if (wait_q > 1) begin
                wait_q <= wait_q - 1;
            end else if (wait_q == 1) begin
                wait_q <= 0;
                if (fail) begin
                    ctl_error <= 1'b1;
                    busy_q <= 1'b0;
                end else if (words_q && cnt_q > 0) begin
                    ctl_tr_req <= 1'b1;
                    ctl_load <= ctl_to_host;
                    ctl_data_in <= 12'ha50 + 12'(cnt_q);
                    cnt_q <= cnt_q - 1;
                end else begin
                    ctl_load <= 1'b1;
                    ctl_to_host <= 1'b1;
                    ctl_data_in <= init_q ? 12'h000 : STATUS;
                    ctl_done <= 1'b1;
                    busy_q <= 1'b0;
                end
            end
        end
    end
endmodule

//--- testbench.sv
`timescale 1ns/1ps

module testbench;
    import floppy_io_pkg::*;

    localparam int DLY = 6;
    localparam logic [11:0] STATUS = 12'h2c5;
    localparam logic [5:0] DC = 6'h3d;
    typedef struct packed {logic [5:0] dev; io_op_t op; logic sk;} row_t;
    logic clk, rst_n, io_strobe, bus_init, fail;
    logic [5:0] io_device;
    logic [2:0] dev_switch, ctl_function, f;
    io_op_t io_op;
    logic [11:0] ac_in, ac_out, ctl_data_out, ctl_data_in, w, g_ac;
    logic ac_load, skip, irq, ctl_load, ctl_to_host, ctl_tr_req, ctl_done, ctl_error;
    logic ctl_run, ctl_init, ctl_drive, ctl_eight_bit, maint_mode, sector_full;
    logic g_load, g_skip, g_run;
    int failures = 0;
    int tests_run = 0;
    int n;
    row_t rows [6] = '{'{6'h38, OP_SKIP_DONE, 1'b0}, '{DC, OP_NOP, 1'b0},
        '{DC, OP_SKIP_DONE, 1'b1}, '{DC, OP_SKIP_DONE, 1'b0},
        '{DC, OP_SKIP_ERROR, 1'b0}, '{DC, OP_SKIP_TRANSFER_REQUEST, 1'b0}};

    // Block under test and its controller stand-in
    floppy_host_io_interface #(
        .INIT_MAX_CYCLES(200)
    ) floppy_host_io_interface_inst (
        .clk(clk), .rst_n(rst_n), .io_strobe(io_strobe), .io_device(io_device),
        .io_op(io_op), .ac_in(ac_in), .dev_switch(dev_switch), .bus_init(bus_init),
        .ac_out(ac_out), .ac_load(ac_load), .skip(skip), .irq(irq),
        .ctl_data_out(ctl_data_out), .ctl_data_in(ctl_data_in), .ctl_load(ctl_load),
        .ctl_to_host(ctl_to_host), .ctl_tr_req(ctl_tr_req), .ctl_done(ctl_done),
        .ctl_error(ctl_error), .ctl_run(ctl_run), .ctl_init(ctl_init),
        .ctl_function(ctl_function), .ctl_drive(ctl_drive),
        .ctl_eight_bit(ctl_eight_bit), .maint_mode(maint_mode),
        .sector_full(sector_full)
    );
    controller_model #(
        .DLY(DLY),
        .STATUS(STATUS)
    ) controller_model_inst (
        .clk(clk), .rst_n(rst_n), .ctl_run(ctl_run), .ctl_init(ctl_init),
        .ctl_function(ctl_function), .fail(fail), .ctl_data_in(ctl_data_in),
        .ctl_load(ctl_load), .ctl_to_host(ctl_to_host), .ctl_tr_req(ctl_tr_req),
        .ctl_done(ctl_done), .ctl_error(ctl_error)
    );

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One instruction; answer sampled in the cycle after the taken edge
    task automatic io(input logic [5:0] dev, input io_op_t op, input logic [11:0] ac);
        @(posedge clk);
        io_strobe <= 1'b1;
        io_device <= dev;
        io_op <= op;
        ac_in <= ac;
        @(posedge clk);
        io_strobe <= 1'b0;
        #1;
        {g_load, g_skip, g_run, g_ac} = {ac_load, skip, ctl_run, ac_out};
    endtask

    task automatic poll(input io_op_t op, output int k);
        for (k = 0; k < 1200; k++) begin
            io(DC, op, 12'h000);
            if (g_skip === 1'b1) break;
        end
        if (k == 1200) chk(12'h000, 12'h001);
    endtask

    // Three-word function, then status readback
    task automatic words(input logic [11:0] cmd, input int pace);
        io(DC, OP_LOAD_COMMAND, cmd);
        repeat (1500) @(posedge clk);
        for (int i = 3; i > 0; i--) begin
            poll(OP_SKIP_TRANSFER_REQUEST, n);
            if (i == 3) chk(12'(n), 12'h000);
            else chk(12'(n * 2 + 2 >= pace - 4 && n * 2 + 2 <= pace + 6), 12'h001);
            w = 12'ha50 + 12'(i);
            io(DC, OP_TRANSFER_DATA, 12'h903);
            if (cmd[1]) begin
                chk(g_ac, cmd[6] ? {4'h9, w[7:0] | 8'h03} : w);
            end else begin
                chk(ctl_data_out, 12'h903);
                chk(12'(g_load), 12'h000);
            end
        end
        poll(OP_SKIP_DONE, n);
        io(DC, OP_TRANSFER_DATA, 12'h900);
        chk(g_ac, cmd[6] ? {4'h9, STATUS[7:0] | 8'h00} : STATUS);
        chk(12'(g_run), 12'h000);
        chk(12'(sector_full), 12'h000);
    endtask

    task automatic end_of_test();
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        end_of_test();
    end

    // Main sequence
    initial begin
        {rst_n, io_strobe, bus_init, fail} = '0;
        {io_device, ac_in} = '0;
        io_op = OP_NOP;
        dev_switch = DC[2:0];
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(12'({ac_load, skip, irq, ctl_run, ctl_eight_bit}), 12'h000);
        bus_init <= 1'b1;
        @(posedge clk);
        bus_init <= 1'b0;
        poll(OP_SKIP_DONE, n);
        chk(12'(n < 20), 12'h001);
        io(DC, OP_SKIP_ERROR, 12'h000);
        chk(12'(g_skip), 12'h000);
        // Every function code, each ending in a controller error
        fail <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            io(DC, OP_LOAD_COMMAND, {5'h00, f[1], 1'b0, f[0], f, 1'b0});
            chk({g_load, g_run, g_ac[9:0]}, 12'hc00);
            chk(g_ac, 12'h000);
            chk(12'({ctl_function, ctl_drive, ctl_eight_bit}), 12'({f, f[0], f[1]}));
            io(DC, OP_LOAD_COMMAND, {8'h00, ~f, 1'b0});
            chk({g_load, g_run, 7'h00, ctl_function}, {2'h2, 7'h00, f});
            poll(OP_SKIP_ERROR, n);
        end
        foreach (rows[i]) begin
            io(rows[i].dev, rows[i].op, 12'h000);
            chk({10'h000, g_load, g_skip}, {11'h000, rows[i].sk});
        end
        fail <= 1'b0;
        words(12'h042, 720);
        words(12'h000, 920);
        // Maintenance: register loop-back, forced flags, interrupt
        io(DC, OP_LOAD_COMMAND, 12'h088);
        chk(12'(maint_mode), 12'h001);
        repeat (DLY + 4) @(posedge clk);
        io(DC, OP_LOAD_COMMAND, 12'hb9a);
        repeat (DLY + 4) @(posedge clk);
        io(DC, OP_TRANSFER_DATA, 12'h000);
        chk(g_ac, 12'hb9a);
        chk(12'(g_run), 12'h000);
        io(DC, OP_SKIP_TRANSFER_REQUEST, 12'h000);
        io(DC, OP_SKIP_TRANSFER_REQUEST, 12'h000);
        chk(12'(g_skip), 12'h001);
        io(DC, OP_INTERRUPT_CONTROL, 12'h001);
        chk(12'(irq), 12'h001);
        io(DC, OP_INTERRUPT_CONTROL, 12'h000);
        chk(12'(irq), 12'h000);
        io(DC, OP_INTERRUPT_CONTROL, 12'h001);
        io(DC, OP_INITIALIZE, 12'h000);
        chk(12'({maint_mode, irq, ctl_eight_bit}), 12'h000);
        io(DC, OP_SKIP_ERROR, 12'h000);
        chk(12'(g_skip), 12'h000);
        repeat (DLY + 4) @(posedge clk);
        chk(12'(irq), 12'h000);
        poll(OP_SKIP_DONE, n);
        chk(12'(n < 20), 12'h001);
        end_of_test();
    end
endmodule
